// ===== include/iecs_pkg.sv
// constants shared by the expander configuration sequencer
package iecs_pkg;
    // ********************************
    // expander register numbers
    // ********************************
    localparam logic [7:0] REG_IN_LOW   = 8'h00;
    localparam logic [7:0] REG_IN_HIGH  = 8'h01;
    localparam logic [7:0] REG_OUT_LOW  = 8'h02;
    localparam logic [7:0] REG_OUT_HIGH = 8'h03;
    localparam logic [7:0] REG_POL_LOW  = 8'h04;
    localparam logic [7:0] REG_POL_HIGH = 8'h05;
    localparam logic [7:0] REG_DIR_LOW  = 8'h06;
    localparam logic [7:0] REG_DIR_HIGH = 8'h07;
    // ********************************
    // fixed data values
    // ********************************
    localparam logic [7:0] NO_INVERT    = 8'h00;
    localparam logic [7:0] ALL_INPUTS   = 8'hFF;
    localparam logic [6:0] ADDR_RESET   = 7'h00;
    // ********************************
    // sequence layout
    // ********************************
    localparam int         NUM_EXP      = 3;
    localparam int         ADDR_W       = 7;
    localparam logic [2:0] STEP_FIRST   = 3'h0;
    localparam logic [2:0] STEP_OUT_HI  = 3'h1;
    localparam logic [2:0] STEP_POL_LO  = 3'h2;
    localparam logic [2:0] STEP_POL_HI  = 3'h3;
    localparam logic [2:0] STEP_DIR_LO  = 3'h4;
    localparam logic [2:0] STEP_DIR_HI  = 3'h5;
    localparam logic [2:0] STEP_RD_LO   = 3'h6;
    localparam logic [2:0] STEP_RD_HI   = 3'h7;
    localparam logic [1:0] EXP_TWO      = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT  = 3'b100
    } iecs_state_e;
endpackage

// ===== include/iecs_watch_if.sv
// pending-configuration handshake between address watcher and sequencer
`timescale 1ns/10ps
interface iecs_watch_if;
    logic [2:0] pending;
    logic [2:0] clear;
    modport watcher (output pending, input clear);
    modport seq     (input pending, output clear);
endinterface

// ===== logic/iecs_addr_watch.sv
// detects changes of each expander slave address field
`timescale 1ns/10ps
module iecs_addr_watch
    import iecs_pkg::*;
(
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    input  wire logic [NUM_EXP-1:0][ADDR_W-1:0] expanderSlaveAddressField,
    iecs_watch_if.watcher                     watch
);
    logic [NUM_EXP-1:0][ADDR_W-1:0] lastAddr;
    logic [2:0]                     pend;
    logic [2:0]                     changed;
    logic [2:0]                     next_pend;

    // ********************************
    // change detect
    // ********************************
    for (genvar i = 0; i < NUM_EXP; i++) begin : g_cmp
        assign changed[i] = lastAddr[i] != expanderSlaveAddressField[i];
    end
    // a change in the same cycle as the clear keeps the request alive
    assign next_pend     = (pend & ~watch.clear) | changed;
    assign watch.pending = pend;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lastAddr <= {NUM_EXP{ADDR_RESET}};
            pend     <= 3'h0;
        end else if (ce) begin
            lastAddr <= expanderSlaveAddressField;
            pend     <= next_pend;
        end
    end
endmodule // iecs_addr_watch

// ===== logic/iecs_sequencer.sv
// expander configuration sequencer for hot-plug expanders zero, one and two
// What this block does
// - for expanders zero and one, zero is written to expander register 5 to keep the upper half uninverted.
// - for expanders zero and one, the lower direction goes to register 6 and then the upper to register 7.
// - every sequence without a transaction error ends by reading register 0 and then register 1 to capture the pin states; an error ends it at the failing step.
// - expander two gets its own sequence.
// - expander two starts with the lower output defaults to register 2 and never writes register 3.
// - expander two then writes zero to register 4 and then zero to register 5.
// - expander two then writes its lower direction setting to register 6.
// - expander two writes all-inputs to register 7 before the pin-state reads.
// - expanders zero and one start with register 2, then register 3, then zero to register 4.
// - a sequence starts whenever that expander's slave address field changes.
// - no expander transaction starts before serial EEPROM initialization is done.
`timescale 1ns/10ps
module iecs_sequencer
    import iecs_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    input  wire logic                           ce,
    input  wire logic                           eepromInitDone,
    input  wire logic [NUM_EXP-1:0][ADDR_W-1:0] expanderSlaveAddressField,
    input  wire logic [NUM_EXP-1:0][15:0]       outDefault,
    input  wire logic [NUM_EXP-1:0][15:0]       dirConfig,
    input  wire logic                           txnDone,
    input  wire logic                           txnError,
    input  wire logic [7:0]                     txnRdData,
    output logic                                txnValid,
    output logic                                txnRead,
    output logic [ADDR_W-1:0]                   txnSlaveAddr,
    output logic [7:0]                          txnCmd,
    output logic [7:0]                          txnWrData,
    output logic [NUM_EXP-1:0][15:0]            pinState,
    output logic [NUM_EXP-1:0]                  pinStateValid,
    output logic [NUM_EXP-1:0]                  seqError,
    output logic                                seqBusy
);
    // ********************************
    // functions
    // ********************************
    function automatic logic [7:0] stepCmd(input logic [2:0] step);
        case (step)
            STEP_FIRST:  stepCmd = REG_OUT_LOW;
            STEP_OUT_HI: stepCmd = REG_OUT_HIGH;
            STEP_POL_LO: stepCmd = REG_POL_LOW;
            STEP_POL_HI: stepCmd = REG_POL_HIGH;
            STEP_DIR_LO: stepCmd = REG_DIR_LOW;
            STEP_DIR_HI: stepCmd = REG_DIR_HIGH;
            STEP_RD_LO:  stepCmd = REG_IN_LOW;
            default:     stepCmd = REG_IN_HIGH;
        endcase
    endfunction

    function automatic logic [7:0] stepData(input logic [2:0] step,
                                            input logic       isTwo,
                                            input logic [15:0] outVal,
                                            input logic [15:0] dirVal);
        case (step)
            STEP_FIRST:  stepData = outVal[7:0];
            STEP_OUT_HI: stepData = outVal[15:8];
            STEP_DIR_LO: stepData = dirVal[7:0];
            // upper half of expander two carries power-good inputs only
            STEP_DIR_HI: stepData = isTwo ? ALL_INPUTS : dirVal[15:8];
            default:     stepData = NO_INVERT;
        endcase
    endfunction

    function automatic logic [1:0] firstPending(input logic [2:0] p);
        if (p[0]) begin
            firstPending = 2'h0;
        end else if (p[1]) begin
            firstPending = 2'h1;
        end else begin
            firstPending = 2'h2;
        end
    endfunction

    // ********************************
    // address watcher
    // ********************************
    iecs_watch_if watch ();

    iecs_addr_watch u_watch (
        .clock                     (clock),
        .rst_n                     (rst_n),
        .ce                        (ce),
        .expanderSlaveAddressField (expanderSlaveAddressField),
        .watch                     (watch.watcher)
    );

    // pending and clear vectors are three bits wide, one per expander
    if (NUM_EXP != 3) begin : g_bad_count
        $error("iecs_sequencer serves exactly three expanders");
    end

    // ********************************
    // decode and selection
    // ********************************
    iecs_state_e     state;
    iecs_state_e     next_state;
    logic [1:0]      curExp;
    logic [2:0]      step;
    logic [ADDR_W-1:0] curAddr;
    wire             startGo;
    wire  [1:0]      pickExp;
    wire             isTwo;
    wire  [2:0]      next_step;
    wire             isRead;
    wire             lastStep;
    wire             doneOk;
    wire             issueNow;
    wire             txnTaken;
    wire             txnFail;
    wire             rdLoDone;
    wire             rdHiDone;
    wire  [7:0]      issueCmd;
    wire  [7:0]      issueData;

    // the master bus is shared with the EEPROM loader, so hold off until it is done
    assign startGo   = (state == ST_IDLE) && eepromInitDone && (|watch.pending);
    assign pickExp   = firstPending(watch.pending);
    assign watch.clear = startGo ? (3'h1 << pickExp) : 3'h0;
    assign isTwo     = curExp == EXP_TWO;
    // expander two skips the upper output-default write
    assign next_step = (isTwo && step == STEP_FIRST) ? STEP_POL_LO : step + 3'h1;
    assign isRead    = step >= STEP_RD_LO;
    assign lastStep  = step == STEP_RD_HI;
    assign issueNow  = state == ST_ISSUE;
    assign txnTaken  = (state == ST_WAIT) && txnDone;
    assign txnFail   = txnTaken && txnError;
    assign doneOk    = txnTaken && !txnError;
    assign rdLoDone  = doneOk && (step == STEP_RD_LO);
    assign rdHiDone  = doneOk && lastStep;
    assign issueCmd  = stepCmd(step);
    assign issueData = stepData(step, isTwo, outDefault[curExp], dirConfig[curExp]);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  if (startGo) next_state = ST_ISSUE;
            ST_ISSUE: next_state = ST_WAIT;
            ST_WAIT: begin
                if (txnDone) begin
                    next_state = (txnError || lastStep) ? ST_IDLE : ST_ISSUE;
                end
            end
            default:  next_state = ST_IDLE;
        endcase
    end

    // ********************************
    // state and step
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            curExp  <= 2'h0;
            step    <= STEP_FIRST;
            curAddr <= ADDR_RESET;
            seqBusy <= 1'b0;
        end else if (ce) begin
            state   <= next_state;
            seqBusy <= next_state != ST_IDLE;
            if (startGo) begin
                curExp  <= pickExp;
                curAddr <= expanderSlaveAddressField[pickExp];
                step    <= STEP_FIRST;
            end else if (doneOk && !lastStep) begin
                step    <= next_step;
            end
        end
    end

    // ********************************
    // transaction request
    // ********************************
    // request data are frozen while valid is high; the master may take its time
    // a done pulse that lands while ce is low is lost, so keep ce high while a request is open
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txnValid     <= 1'b0;
            txnRead      <= 1'b0;
            txnSlaveAddr <= ADDR_RESET;
            txnCmd       <= REG_IN_LOW;
            txnWrData    <= NO_INVERT;
        end else if (ce) begin
            if (issueNow) begin
                txnValid     <= 1'b1;
                txnRead      <= isRead;
                txnSlaveAddr <= curAddr;
                txnCmd       <= issueCmd;
                txnWrData    <= issueData;
            end else if (txnTaken) begin
                txnValid     <= 1'b0;
            end
        end
    end

    // ********************************
    // pin state capture and status
    // ********************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinState      <= '0;
            pinStateValid <= '0;
            seqError      <= '0;
        end else if (ce) begin
            if (startGo) begin
                pinStateValid[pickExp] <= 1'b0;
                seqError[pickExp]      <= 1'b0;
            end
            if (txnFail) begin
                seqError[curExp] <= 1'b1;
            end
            if (rdLoDone) begin
                pinState[curExp][7:0] <= txnRdData;
            end
            if (rdHiDone) begin
                pinState[curExp][15:8] <= txnRdData;
                pinStateValid[curExp]  <= 1'b1;
            end
        end
    end
endmodule // iecs_sequencer

// ===== tb/iecs_properties.sv
// assertions for the expander configuration sequencer
`timescale 1ns/10ps
module iecs_properties
    import iecs_pkg::*;
(
    input wire logic                           clock,
    input wire logic                           rst_n,
    input wire logic                           ce,
    input wire logic                           eepromInitDone,
    input wire logic [NUM_EXP-1:0][ADDR_W-1:0] expanderSlaveAddressField,
    input wire logic                           txnDone,
    input wire logic                           txnError,
    input wire logic                           txnValid,
    input wire logic                           txnRead,
    input wire logic [ADDR_W-1:0]              txnSlaveAddr,
    input wire logic [7:0]                     txnCmd,
    input wire logic [7:0]                     txnWrData,
    input wire logic                           seqBusy
);
    // ********************************
    // ordering and handshake checks
    // ********************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_done(logic [7:0] c);
        ce && txnValid && txnDone && !txnError && txnCmd == c;
    endsequence
    property p_gate; !eepromInitDone && !seqBusy |=> ##1 !txnValid; endproperty
    a_gate: assert property (p_gate) else $error("request before eeprom init");
    property p_hold;
        txnValid && !(ce && txnDone) |=> txnValid
            && $stable({txnRead, txnSlaveAddr, txnCmd, txnWrData});
    endproperty
    a_hold: assert property (p_hold) else $error("request changed while open");
    property p_drop; ce && txnValid && txnDone |=> !txnValid; endproperty
    a_drop: assert property (p_drop) else $error("request held after done");
    property p_kind; txnValid |-> txnCmd < 8'h08 && txnRead == (txnCmd < 8'h02); endproperty
    a_kind: assert property (p_kind) else $error("bad command or kind");
    // the far expander is told apart by its address, so addresses must stay unique
    property p_outLo;
        s_done(REG_OUT_LOW) |=> ##1 txnValid && !txnRead && txnCmd ==
            (txnSlaveAddr == expanderSlaveAddressField[EXP_TWO] ? REG_POL_LOW : REG_OUT_HIGH);
    endproperty
    a_outLo: assert property (p_outLo) else $error("wrong step after reg 2");
    property p_polLo;
        s_done(REG_POL_LOW) |=> ##1 txnValid && txnCmd == REG_POL_HIGH && txnWrData == NO_INVERT;
    endproperty
    a_polLo: assert property (p_polLo) else $error("wrong step after reg 4");
    property p_dirLo; s_done(REG_DIR_LOW) |=> ##1 txnValid && txnCmd == REG_DIR_HIGH; endproperty
    a_dirLo: assert property (p_dirLo) else $error("wrong step after reg 6");
    property p_dirHi;
        s_done(REG_DIR_HIGH) |=> ##1 txnValid && txnRead && txnCmd == REG_IN_LOW;
    endproperty
    a_dirHi: assert property (p_dirHi) else $error("wrong step after reg 7");
    property p_rdLo; s_done(REG_IN_LOW) |=> ##1 txnValid && txnRead && txnCmd == REG_IN_HIGH;
    endproperty
    a_rdLo: assert property (p_rdLo) else $error("wrong step after reg 0");
    property p_outHi;
        s_done(REG_OUT_HIGH) |=> ##1 txnValid && txnCmd == REG_POL_LOW
            && txnWrData == NO_INVERT;
    endproperty
    a_outHi: assert property (p_outHi) else $error("wrong step after reg 3");
    property p_rdHi; s_done(REG_IN_HIGH) |=> !txnValid && !seqBusy; endproperty
    a_rdHi: assert property (p_rdHi) else $error("sequence not ended after reg 1");
    property p_allIn;
        txnValid && txnCmd == REG_DIR_HIGH && txnSlaveAddr == expanderSlaveAddressField[EXP_TWO]
            |-> txnWrData == ALL_INPUTS;
    endproperty
    a_allIn: assert property (p_allIn) else $error("upper half not all inputs");
endmodule // iecs_properties
bind iecs_sequencer iecs_properties u_props (.clock, .rst_n, .ce, .eepromInitDone,
    .expanderSlaveAddressField, .txnDone, .txnError, .txnValid, .txnRead, .txnSlaveAddr,
    .txnCmd, .txnWrData, .seqBusy);

// ===== tb/iecs_smb_model.sv
// behavioural smbus master with the expanders behind it
`timescale 1ns/10ps
module iecs_smb_model
    import iecs_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              txnValid,
    input  wire logic              txnRead,
    input  wire logic [ADDR_W-1:0] txnSlaveAddr,
    input  wire logic [7:0]        txnCmd,
    input  wire logic [7:0]        errCmd,
    output logic                   txnDone,
    output logic                   txnError,
    output logic [7:0]             txnRdData
);
    int stallSeed;
    // ********************************
    // random stall, read data scrambled when idle
    // ********************************
    initial begin
        txnDone = 1'b0;
        txnError = 1'b0;
        txnRdData = 8'h00;
        stallSeed = 32'h20b7_2ff3;
    end
    always @(posedge clock) begin
        #1;
        txnRdData <= ~txnRdData;
        txnDone <= 1'b0;
        txnError <= 1'b0;
        if (txnValid && !txnDone && ($random(stallSeed) & 3) == 0) begin
            txnDone <= 1'b1;
            txnError <= (txnCmd == errCmd);
            if (txnRead)
                txnRdData <= {txnSlaveAddr, txnCmd[0]};
        end
    end
endmodule // iecs_smb_model

// ===== tb/testbench.sv
// randomised bench for the expander configuration sequencer
`timescale 1ns/10ps
module testbench import iecs_pkg::*;;
    logic clock, rst_n, ce, eepromInitDone, txnDone, txnError, txnValid, txnRead, seqBusy;
    logic [NUM_EXP-1:0][ADDR_W-1:0] addrField;
    logic [NUM_EXP-1:0][15:0]       outDefault, dirConfig, pinState;
    logic [NUM_EXP-1:0]             pinStateValid, seqError;
    logic [ADDR_W-1:0]              txnSlaveAddr;
    logic [7:0]                     txnCmd, txnWrData, txnRdData, errCmd;
    logic [23:0]                    q[$];
    int                             errors, nCompared, seed, t;
    iecs_sequencer u_dut (.clock, .rst_n, .ce, .eepromInitDone,
        .expanderSlaveAddressField(addrField), .outDefault, .dirConfig, .txnDone, .txnError,
        .txnRdData, .txnValid, .txnRead, .txnSlaveAddr, .txnCmd, .txnWrData, .pinState,
        .pinStateValid, .seqError, .seqBusy);
    iecs_smb_model u_smb (.clock, .txnValid, .txnRead, .txnSlaveAddr, .txnCmd, .errCmd,
        .txnDone, .txnError, .txnRdData);
    // ********************************
    // helpers, monitor and tests
    // ********************************
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // expected steps; an error stops the list at the failing step
    task automatic plan(input int e);
        logic [7:0] c;
        logic [7:0] d;
        bit stop;
        stop = 0;
        for (int s = 0; s < 8; s++) begin
            c = (s < 6) ? 8'(s + 2) : 8'(s - 6);
            d = (s < 2) ? outDefault[e][8*s+:8] : (s < 4) ? NO_INVERT : dirConfig[e][8*(s-4)+:8];
            if (e == 2 && s == 5) d = ALL_INPUTS;
            if (s > 5) d = 8'h00;
            if (!(e == 2 && s == 1) && !stop) q.push_back({addrField[e], 1'(s > 5), c, d});
            if (c == errCmd) stop = 1;
        end
    endtask
    task automatic kick(input int e);
        logic [ADDR_W-1:0] a;
        a = {2'(e), 1'b1, 4'($random(seed))};
        if (a === addrField[e]) a[0] = ~a[0];
        outDefault[e] = 16'($random(seed));
        dirConfig[e] = 16'($random(seed));
        addrField[e] = a;
        plan(e);
    endtask
    task automatic settle;
        int n;
        n = 0;
        while ((q.size() != 0 || seqBusy !== 1'b0) && n < 3000) begin
            tick(1);
            n++;
        end
        chk(n, n % 3000);
    endtask
    task automatic pins(input int e);
        chk({seqError[e], pinStateValid[e], pinState[e]},
            {1'h0, 1'h1, addrField[e], 1'h1, addrField[e], 1'h0});
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clock) begin
        if (txnValid && txnDone) begin
            if (q.size() == 0) chk(32'h1, 32'h0);
            else begin
                chk({txnSlaveAddr, txnRead, txnCmd, txnRead ? 8'h00 : txnWrData}, q[0]);
                q.delete(0);
            end
        end
    end
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    initial begin
        seed = 32'h20b7_2ff3;
        {errors, nCompared} = 0;
        {rst_n, eepromInitDone, addrField, outDefault, dirConfig} = '0;
        ce = 1'b1;
        errCmd = 8'hFF;
        tick(3);
        rst_n = 1'b1;
        kick(0);
        tick(40);
        chk({seqBusy, txnValid, 8'(q.size())}, 10'h008);
        eepromInitDone = 1'b1;
        settle();
        pins(0);
        $display("test gate done");
        for (t = 0; t < 6; t++) begin
            kick(t % 3);
            settle();
            pins(t % 3);
        end
        $display("test random done");
        kick(0);
        kick(2);
        settle();
        pins(0);
        pins(2);
        kick(1);
        tick(6);
        chk(seqBusy, 1);
        kick(0);
        settle();
        pins(1);
        pins(0);
        $display("test overlap done");
        errCmd = REG_DIR_LOW;
        kick(2);
        settle();
        chk({seqError[2], pinStateValid[2]}, 2'b10);
        errCmd = 8'hFF;
        kick(2);
        settle();
        pins(2);
        $display("test error done");
        ce = 1'h0;
        kick(1);
        tick(20);
        chk({seqBusy, txnValid, 8'(q.size())}, 10'h008);
        ce = 1'h1;
        settle();
        pins(1);
        $display("test enable done");
        kick(1);
        tick(10);
        rst_n = 1'b0;
        tick(1);
        chk({txnValid, seqBusy, pinStateValid, seqError}, 0);
        q.delete();
        rst_n = 1'b1;
        for (t = 0; t < 3; t++) plan(t);
        settle();
        for (t = 0; t < 3; t++) pins(t);
        $display("test reset done");
        give_verdict();
    end
endmodule // testbench
